// ### tb/accept_src.sv
// partner: first-level accept source of the trigger side
// assumes burst is a one-cycle request from the bench
`timescale 1ns/100ps
module accept_src (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // request and accept pulses
  input wire logic [1:0] burst,
  output logic           l1_accept
);
  logic [1:0] left_ff;   // accepts still to send
  logic [1:0] nxt_left;
  // back-to-back accepts, one per high cycle
  assign nxt_left = (burst != 2'h0) ? burst : left_ff - {1'b0, left_ff != 2'h0};
  assign l1_accept = left_ff != 2'h0;
  // count register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) left_ff <= 2'h0;
    else left_ff <= nxt_left;
  end
endmodule

// ### tb/calo_chk.sv
// checker: port timing of the channel chain
// assumes zero-wait apb and registered trigger outputs
`timescale 1ns/100ps
`include "calo_consts.svh"
module calo_chk #(
  parameter int N_DRB = 8  // buffers watched
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             nrst,
  // bench-driven inputs
  input wire logic             l1_accept,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  // design outputs
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [10:0]      energy_out,
  input wire logic             bcf_out,
  input wire logic             pileup_out,
  input wire logic [N_DRB-1:0] drb_ready,
  input wire logic             fatal_out,
  input wire logic             nonfatal_out
);
  // write strobes to the two clearing registers
  wire wr_stat = psel && penable && pwrite && paddr == `A_STAT;
  wire wr_free = psel && penable && pwrite && paddr == `A_FREE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_setup; psel && !penable ##1 psel && penable; endsequence
  property p_rdy; s_setup |-> pready; endproperty
  property p_idle; !(psel && penable) |-> !pready && !pslverr; endproperty
  property p_egy; energy_out != 11'h000 |-> bcf_out; endproperty
  property p_fz; fatal_out |-> energy_out == 11'h000; endproperty
  property p_pu; $changed(pileup_out) |-> $past(bcf_out); endproperty
  // a new frame is complete exactly 16 edges after its accept
  property p_frm; |(drb_ready & ~$past(drb_ready)) |-> $past(l1_accept, 16); endproperty
  property p_rel; |(~drb_ready & $past(drb_ready)) |-> $past(wr_free); endproperty
  property p_fat; $fell(fatal_out) |-> $past(wr_stat); endproperty
  property p_nf; $fell(nonfatal_out) |-> $past(wr_stat); endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing in access");
  a_idle: assert property (p_idle) else $error("answer outside access");
  a_egy: assert property (p_egy) else $error("energy without flag");
  a_fz: assert property (p_fz) else $error("energy during fatal");
  a_pu: assert property (p_pu) else $error("pileup moved off flag");
  a_frm: assert property (p_frm) else $error("frame timing wrong");
  a_rel: assert property (p_rel) else $error("frame lost unasked");
  a_fat: assert property (p_fat) else $error("fatal cleared alone");
  a_nf: assert property (p_nf) else $error("nonfatal cleared alone");
endmodule
bind calorimeter_channel_processing calo_chk #(.N_DRB(N_DRB)) u_chk (
  .clk(clk), .nrst(nrst), .l1_accept(l1_accept), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .energy_out(energy_out), .bcf_out(bcf_out), .pileup_out(pileup_out),
  .drb_ready(drb_ready), .fatal_out(fatal_out), .nonfatal_out(nonfatal_out));

// ### tb/tb.sv
// testbench: apb register checks and frame capture
// assumes zero-wait apb and a two-buffer build
`timescale 1ns/100ps
`include "calo_consts.svh"
module tb;
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  calo_pkg::chan_t [4:0] ch_in = '0;
  logic                  l1_accept;
  logic [1:0]            burst = 2'h0, drb_ready;
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h0, prdata, q;
  logic                  pready, pslverr, e, fatal_out;
  logic                  bcf_out, pileup_out, severe_out;
  logic [10:0]           energy_out;
  logic [31:0]           l2_result;
  logic [17:0]           cyc = 18'h0, dv;
  int                    mismatches = 0, checks_done = 0;
  int                    lat[3] = '{4, 256, 1};
  logic [31:0]           cfg[3] = '{32'h4, 32'h100, 32'h204};
  always #10 clk = ~clk;
  // ramp on every channel so each sample names its cycle
  always @(posedge clk) begin
    cyc <= cyc + 18'h1;
    for (int i = 0; i < 5; i++) ch_in[i] <= {1'b0, cyc};
  end
  calorimeter_channel_processing #(.PIPE_CH(0), .N_DRB(2)) u_calorimeter_channel_processing (
    .clk(clk), .nrst(nrst), .ch_in(ch_in), .l1_accept(l1_accept), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .energy_out(energy_out), .bcf_out(bcf_out), .pileup_out(pileup_out),
    .severe_out(severe_out), .l2_result(l2_result), .drb_ready(drb_ready), .fatal_out(fatal_out), .nonfatal_out());
  accept_src u_accept_src (.clk(clk), .nrst(nrst), .burst(burst), .l1_accept(l1_accept));
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  // one apb transfer; wait on pready is bounded
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      final_report;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // request n accepts, note the sample seen in the first one
  task fire(input logic [1:0] n);
    @(posedge clk);
    burst <= n;
    @(posedge clk);
    burst <= 2'h0;
    @(negedge clk);
    dv = ch_in[0].data;
  endtask
  initial begin
    int b;
    int s;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, `A_CTRL, 32'h0);
    chk("ctrl_rst", q, 32'h4);
    apb(1'b1, `A_CTRL, 32'h3);
    chk("dly_low", e, 1);
    apb(1'b1, `A_CTRL, 32'h101);
    chk("dly_high", e, 1);
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped", e, 1);
    // second-level store starts unknown, so fill it
    for (int i = 0; i < 384; i++) apb(1'b1, 12'(`A_L2C + 4 * i), 32'h0);
    apb(1'b1, `A_STAT, 32'h1F);
    @(negedge clk);
    chk("no_fatal", fatal_out, 0);
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, `A_CTRL, cfg[c]);
      apb(1'b0, `A_CTRL, 32'h0);
      chk("ctrl", q, cfg[c]);
      repeat (300) @(posedge clk);
      fire(2'h2);
      repeat (17) @(negedge clk);
      chk("both_ready", drb_ready, 2'h3);
      for (int k = 0; k < 4; k++) begin
        b = k / 2;
        s = (k % 2) * 15;
        apb(1'b0, 12'(`A_DRB + b * 64 + s * 4), 32'h0);
        chk("frame", q[21:4], 18'(dv + b + s - lat[c]));
      end
      apb(1'b1, `A_FREE, 32'h3);
      @(negedge clk);
      chk("freed", drb_ready, 2'h0);
    end
    // channel 0 only, unit taps, edge finder
    apb(1'b1, `A_CTRL, 32'h404);
    for (int i = 1; i < 5; i++) apb(1'b1, 12'(`A_ATHR + 4 * i), `THR_OFF);
    apb(1'b1, `A_ECOF, 32'h1);
    apb(1'b1, `A_TCOF, 32'h1);
    s = int'(cyc[17:2]) + 16;
    apb(1'b1, `A_TTHR, s);
    b = 0;
    repeat (200) begin
      @(negedge clk);
      if (bcf_out) begin
        b++;
        q = energy_out;
      end
    end
    chk("bcf_count", b, 1);
    chk("energy", q, (s * 4) % 2048);
    chk("l2_zero", l2_result, 0);
    // peak mode flags every fourth clock
    apb(1'b1, `A_PILE, 32'h0305);
    apb(1'b1, `A_CTRL, 32'h4);
    repeat (20) @(negedge clk);
    chk("pileup", {pileup_out, severe_out}, 2'h2);
    fire(2'h3);
    repeat (17) @(negedge clk);
    chk("overflow", fatal_out, 1);
    apb(1'b0, `A_STAT, 32'h0);
    chk("stat_ovf", q[4], 1);
    apb(1'b1, `A_STAT, 32'h1F);
    @(negedge clk);
    chk("fatal_clr", fatal_out, 0);
    repeat (2) @(posedge clk);
    final_report;
  end
endmodule

// ### verilog/calo_consts.svh
// offsets, field positions, reset values and counts for the channel chain
// assumes a 12-bit APB byte address and 32-bit data
`ifndef CALO_CONSTS_SVH
`define CALO_CONSTS_SVH
`define A_CTRL    12'h000
`define A_STAT    12'h004
`define A_FREE    12'h008
`define A_PILE    12'h00C
`define A_ETHR    12'h010
`define A_ESHF    12'h014
`define A_TTHR    12'h018
`define A_ATHR    12'h020
`define A_ECOF    12'h040
`define A_TCOF    12'h060
`define A_DRB     12'h200
`define A_L2C     12'h800
`define A_L2END   12'hE00
`define F_DLY     8:0
`define F_BYP     9
`define F_BCM     10
`define F_OS      12:11
`define F_BKX     13
`define F_BANK    16:14
`define CTRL_RST  17'h00004
`define DLY_MIN   9'h004
`define DLY_MAX   9'h100
`define FRAME_LEN 5'h10
`define THR_OFF   20'hFFFFF
`define T_TRUNC   2'h2
`define GAP_SAT   8'hFF
`endif

// ### verilog/calo_pkg.sv
// types shared by the channel processing chain
// assumes calo_consts.svh carries all numeric constants
package calo_pkg;
  // one channel from the linearizer: linear sample plus integrity flag
  typedef struct packed {
    logic        err;
    logic [17:0] data;
  } chan_t;
  // word stored in the rotating buffer, before the ecc envelope
  typedef struct packed {
    logic [17:0] sample;
    logic        integ;
    logic        bcf;
    logic        pu;
    logic        spu;
  } pipe_word_t;
  // first-level tap: parity, residue and 7-bit signed coefficient
  typedef struct packed {
    logic       par;
    logic [1:0] res;
    logic [6:0] coef;
  } coef1_t;
  // second-level word: parity, residue and 10-bit signed coefficient
  typedef struct packed {
    logic       par;
    logic [1:0] res;
    logic [9:0] coef;
  } coef2_t;
  // order-statistics criterion
  typedef enum logic [1:0] {
    OS_MAX = 2'h0,
    OS_MIN = 2'h1,
    OS_MED = 2'h2
  } os_crit_t;
endpackage

// ### verilog/calorimeter_channel_processing.sv
// channel chain: pipeline, derandomizers, adder, first and second level filters
// assumes linearizer data on clk, APB master on clk, active-low async reset
// Functional notes
// - pipeline delay programmable from 4 to 256
// - sample plus flags ecc-encoded, written every clock
// - test bypass around rotating buffer
// - accept copies 16 samples into free buffer
// - overlapping accepts each get a full frame
// - ecc decoder corrects, raises non-fatal error
// - sum of five strip channels each clock
// - per-input threshold, zero on integrity error
// - all-ones threshold switches channel off
// - residue-3 check on adder, fatal on mismatch
// - two six-tap fir filters, energy and timing
// - 7-bit signed taps with residue and parity
// - energy full resolution, timing drops two lsbs
// - residue-3 shadow filters, fatal on mismatch
// - energy threshold then 11-bit sliding window
// - peak or leading-edge finder makes crossing flag
// - gap counter against two limits into pipeline
// - energy zero except at crossing flag
// - three l2 firs, 8x16 banked coefficient stores
// - l2 word: 10-bit coefficient, residue, parity
// - order statistics picks max, min or median
// - l2 parity and residue checks are fatal
// - eight derandomizing buffers
// - all parameters loaded over control bus
// - fatal zeroes trigger data, marks readout bad
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "calo_consts.svh"

module calorimeter_channel_processing #(
  parameter int PIPE_CH = 0,  // channel stored in the pipeline
  parameter int N_DRB   = 8   // derandomizing buffers
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             nrst,
  // linearizer channels and first-level accept
  input  wire calo_pkg::chan_t [4:0]            ch_in,
  input  wire logic                             l1_accept,
  // apb slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [11:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  output logic [31:0]                           prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // trigger primitive side
  output logic [10:0]                           energy_out,
  output logic                                  bcf_out,
  output logic                                  pileup_out,
  output logic                                  severe_out,
  // readout side
  output logic signed [31:0]                    l2_result,
  output logic [N_DRB-1:0]                      drb_ready,
  output logic                                  fatal_out,
  output logic                                  nonfatal_out
);

  if (PIPE_CH < 0 || PIPE_CH > 4 || N_DRB < 1 || N_DRB > 8) begin
    $error("calorimeter_channel_processing: unsupported parameters");
  end

  // residue modulo 3 of a signed value, always 0..2
  function automatic logic [1:0] mod3(input logic signed [31:0] v);
    int m;
    m = int'(v % 3);
    if (m < 0) begin
      m = m + 3;
    end
    return 2'(m);
  endfunction

  // hamming syndrome over the 27 codeword positions
  function automatic logic [4:0] ecc_syn(input logic [26:0] cw);
    logic [4:0] s;
    s = '0;
    for (int p = 1; p <= 27; p++) begin
      if (cw[p-1]) begin
        s = s ^ 5'(p);
      end
    end
    return s;
  endfunction

  // data goes to non-power-of-two positions, check bits zero the syndrome
  function automatic logic [26:0] ecc_enc(input logic [21:0] d);
    logic [26:0] cw;
    logic [4:0]  s;
    int          j;
    cw = '0;
    j  = 0;
    for (int p = 1; p <= 27; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p-1] = d[j];
        j++;
      end
    end
    s = ecc_syn(cw);
    for (int b = 0; b < 5; b++) begin
      cw[(1 << b) - 1] = s[b];
    end
    return cw;
  endfunction

  // returns {corrected, data}; single flips are repaired in place
  function automatic logic [22:0] ecc_dec(input logic [26:0] cw_in);
    logic [26:0] cw;
    logic [21:0] d;
    logic [4:0]  s;
    int          j;
    cw = cw_in;
    d  = '0;
    j  = 0;
    s  = ecc_syn(cw);
    if (s != 5'h00 && s <= 5'h1B) begin
      cw[s-1] = ~cw[s-1];
    end
    for (int p = 1; p <= 27; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = cw[p-1];
        j++;
      end
    end
    return {s != 5'h00, d};
  endfunction

  // residue and parity are formed when the coefficient is loaded
  function automatic calo_pkg::coef1_t mk1(input logic [6:0] c);
    calo_pkg::coef1_t w;
    w.coef = c;
    w.res  = mod3(32'($signed(c)));
    w.par  = ^{w.res, c};
    return w;
  endfunction

  function automatic calo_pkg::coef2_t mk2(input logic [9:0] c);
    calo_pkg::coef2_t w;
    w.coef = c;
    w.res  = mod3(32'($signed(c)));
    w.par  = ^{w.res, c};
    return w;
  endfunction

  // six-tap fir; sh drops low input bits
  function automatic logic signed [31:0] fir6(input calo_pkg::coef1_t [5:0] c,
                                              input logic [5:0][20:0] x, input logic [1:0] sh);
    logic signed [31:0] s;
    s = '0;
    for (int k = 0; k < 6; k++) begin
      s = s + 32'($signed(c[k].coef)) * $signed(32'(x[k] >> sh));
    end
    return s;
  endfunction

  // residue-3 shadow of fir6, built only from residues
  function automatic logic [1:0] res6(input calo_pkg::coef1_t [5:0] c,
                                      input logic [5:0][20:0] x, input logic [1:0] sh);
    int r;
    r = 0;
    for (int k = 0; k < 6; k++) begin
      r = r + int'(c[k].res) * int'(mod3(32'(x[k] >> sh)));
    end
    return mod3(32'(r));
  endfunction

  // lowest free buffer as {found, index}
  function automatic logic [3:0] first_free(input logic [N_DRB-1:0] busy);
    logic [3:0] r;
    r = '0;
    for (int i = N_DRB - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // register file
  logic [16:0]              ctrl_ff;      // delay, bypass, modes, bank
  logic [4:0]               stat_ff;      // sticky error flags, w1c
  logic [7:0]               pu_lim_ff;    // pileup gap limit
  logic [7:0]               spu_lim_ff;   // severe pileup gap limit
  logic [20:0]              e_thr_ff;     // energy threshold
  logic [4:0]               e_shf_ff;     // window start bit
  logic [31:0]              t_thr_ff;     // leading-edge threshold
  logic [4:0][19:0]         a_thr_ff;     // adder input thresholds
  calo_pkg::coef1_t [5:0]   e_cof_ff;     // energy fir taps
  calo_pkg::coef1_t [5:0]   t_cof_ff;     // timing fir taps
  calo_pkg::coef2_t         l2c_mem [0:383]; // 3 filters x 8 banks x 16
  logic [31:0]              prdata_ff;    // read data, taken in setup

  // datapath state
  logic [26:0]              ring [0:255]; // rotating buffer
  logic [7:0]               wptr_ff;
  logic [26:0]              rd_ff;        // buffer read word
  logic [26:0]              byp_ff;       // bypass word
  logic [22:0]              drb_mem [0:7][0:15]; // {bad, pipe word}
  logic [N_DRB-1:0]         busy_ff;
  logic [4:0]               cnt_ff [N_DRB];
  logic [20:0]              sum_ff;
  logic [5:0][20:0]         x_ff;         // l1 input history, [0] newest
  logic signed [31:0]       e_ff, e1_ff, t_ff, t1_ff, t2_ff;
  logic                     bcf_ff, pu_ff, spu_ff;
  logic [7:0]               gap_ff;       // clocks since last flag
  logic [10:0]              energy_ff;
  logic [15:0][17:0]        y_ff;         // l2 input history
  logic signed [31:0]       r_ff [3];     // l2 filter results
  logic signed [31:0]       l2_ff;

  // apb decode
  wire        acc      = psel & penable;
  wire        setup    = psel & ~penable;
  wire [11:0] a        = paddr;
  wire        in_athr  = a[11:5] == 7'h01 && a[4:2] < 3'h5 && a[1:0] == 2'h0;
  wire        in_ecof  = a[11:5] == 7'h02 && a[4:2] < 3'h6 && a[1:0] == 2'h0;
  wire        in_tcof  = a[11:5] == 7'h03 && a[4:2] < 3'h6 && a[1:0] == 2'h0;
  wire        in_drb   = a[11:9] == 3'h1 && 32'(a[8:6]) < N_DRB && a[1:0] == 2'h0;
  wire        in_l2c   = a >= `A_L2C && a < `A_L2END && a[1:0] == 2'h0;
  wire [8:0]  l2_idx   = 9'((a - `A_L2C) >> 2);
  wire        in_reg   = a == `A_CTRL || a == `A_STAT || a == `A_FREE || a == `A_PILE
                         || a == `A_ETHR || a == `A_ESHF || a == `A_TTHR;
  wire        mapped   = in_reg | in_athr | in_ecof | in_tcof | in_drb | in_l2c;
  // out-of-range delay is refused and the old length kept
  wire        dly_bad  = pwrite && a == `A_CTRL
                         && (pwdata[`F_DLY] < `DLY_MIN || pwdata[`F_DLY] > `DLY_MAX);
  wire        wr       = acc & pwrite & ~pslverr;
  assign pready  = acc;
  assign pslverr = acc & (~mapped | dly_bad);
  assign prdata  = prdata_ff;

  // read mux, sampled one cycle before the access phase
  logic [31:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (a == `A_CTRL) begin
      rd_word = 32'(ctrl_ff);
    end else if (a == `A_STAT) begin
      rd_word = {8'h00, 8'(drb_ready), 8'(busy_ff), 3'h0, stat_ff};
    end else if (a == `A_PILE) begin
      rd_word = {16'h0000, spu_lim_ff, pu_lim_ff};
    end else if (a == `A_ETHR) begin
      rd_word = 32'(e_thr_ff);
    end else if (a == `A_ESHF) begin
      rd_word = 32'(e_shf_ff);
    end else if (a == `A_TTHR) begin
      rd_word = t_thr_ff;
    end else if (in_athr) begin
      rd_word = 32'(a_thr_ff[a[4:2]]);
    end else if (in_ecof) begin
      rd_word = 32'(e_cof_ff[a[4:2]].coef);
    end else if (in_tcof) begin
      rd_word = 32'(t_cof_ff[a[4:2]].coef);
    end else if (in_drb) begin
      rd_word = 32'(drb_mem[a[8:6]][a[5:2]]);
    end else if (in_l2c) begin
      rd_word = 32'(l2c_mem[l2_idx].coef);
    end
  end

  // adder: thresholds, switch-off and residue check
  logic [20:0] sum;
  logic        add_bad;
  always_comb begin
    logic [17:0] v;
    int          rs;
    v   = '0;
    rs  = 0;
    sum = '0;
    for (int i = 0; i < 5; i++) begin
      v = ch_in[i].data;
      if (ch_in[i].err || a_thr_ff[i] == `THR_OFF
          || {2'h0, ch_in[i].data} < a_thr_ff[i]) begin
        v = '0;
      end
      sum = sum + 21'(v);
      rs  = rs + int'(mod3(32'(v)));
    end
    add_bad = mod3(32'(sum)) != mod3(32'(rs));
  end

  // first-level filters with residue shadows and tap parity
  logic signed [31:0] e_fir, t_fir;
  logic               l1_bad;
  always_comb begin
    logic par_bad;
    par_bad = 1'b0;
    for (int k = 0; k < 6; k++) begin
      par_bad = par_bad | ^e_cof_ff[k] | ^t_cof_ff[k];
    end
    e_fir  = fir6(e_cof_ff, x_ff, 2'h0);
    t_fir  = fir6(t_cof_ff, x_ff, `T_TRUNC);
    l1_bad = par_bad || mod3(e_fir) != res6(e_cof_ff, x_ff, 2'h0)
             || mod3(t_fir) != res6(t_cof_ff, x_ff, `T_TRUNC);
  end

  // crossing finder: peak marks the middle sample, edge the crossing one
  wire peak = t1_ff > t2_ff && t1_ff >= t_ff;
  wire edge_hit = t_ff >= $signed(t_thr_ff) && t1_ff < $signed(t_thr_ff);
  wire bcf_nxt = ctrl_ff[`F_BCM] ? edge_hit : peak;
  wire signed [31:0] e_sel = ctrl_ff[`F_BCM] ? e_ff : e1_ff;
  wire signed [31:0] e_th = e_sel < $signed(32'(e_thr_ff)) ? 32'sh0 : e_sel;
  wire [10:0] e_win = 11'(e_th >>> e_shf_ff);
  wire        fatal_any = |stat_ff[4:1];

  // pipeline: merge sample with filter flags, ecc wrap, ring write
  calo_pkg::pipe_word_t pw_in, pipe_dout;
  logic [26:0] enc;
  logic        ecc_fix;
  wire  [8:0]  rd_sum  = {1'b0, wptr_ff} + 9'h001 - ctrl_ff[`F_DLY];
  wire  [7:0]  rd_addr = rd_sum[7:0];
  assign pw_in = '{sample: ch_in[PIPE_CH].data, integ: ch_in[PIPE_CH].err,
                   bcf: bcf_ff, pu: pu_ff, spu: spu_ff};
  assign enc   = ecc_enc(pw_in);
  assign {ecc_fix, pipe_dout} = ecc_dec(ctrl_ff[`F_BYP] ? byp_ff : rd_ff);

  // derandomizer allocation; entries carry the fatal mark for readout
  wire [3:0]  ff       = first_free(busy_ff);
  wire        alloc    = l1_accept & ff[3];
  wire        overflow = l1_accept & ~ff[3];
  wire [22:0] dword    = {fatal_any, pipe_dout};
  wire        wr_free  = wr && a == `A_FREE;

  // second-level filters over the pipeline output
  logic [2:0]         bank;
  logic signed [31:0] l2_acc [3];
  logic               l2_bad;
  assign bank = ctrl_ff[`F_BKX] ? ctrl_ff[`F_BANK] : {pipe_dout.spu, pipe_dout.pu, pipe_dout.bcf};
  always_comb begin
    calo_pkg::coef2_t w;
    int               r;
    w      = '0;
    r      = 0;
    l2_bad = 1'b0;
    for (int f = 0; f < 3; f++) begin
      l2_acc[f] = '0;
      r = 0;
      for (int k = 0; k < 16; k++) begin
        w = l2c_mem[f * 128 + int'(bank) * 16 + k];
        l2_bad = l2_bad | ^w;
        l2_acc[f] = l2_acc[f] + 32'($signed(w.coef)) * $signed(32'(y_ff[k]));
        r = r + int'(w.res) * int'(mod3(32'(y_ff[k])));
      end
      l2_bad = l2_bad | (mod3(l2_acc[f]) != mod3(32'(r)));
    end
  end

  // order statistics over the three registered results
  wire signed [31:0] mx01 = r_ff[0] > r_ff[1] ? r_ff[0] : r_ff[1];
  wire signed [31:0] mn01 = r_ff[0] > r_ff[1] ? r_ff[1] : r_ff[0];
  wire signed [31:0] omax = mx01 > r_ff[2] ? mx01 : r_ff[2];
  wire signed [31:0] omin = mn01 < r_ff[2] ? mn01 : r_ff[2];
  wire signed [31:0] mmid = mx01 < r_ff[2] ? mx01 : r_ff[2];
  wire signed [31:0] omed = mn01 > mmid ? mn01 : mmid;
  logic signed [31:0] os_out;
  always_comb begin
    unique case (calo_pkg::os_crit_t'(ctrl_ff[`F_OS]))
      calo_pkg::OS_MIN: os_out = omin;
      calo_pkg::OS_MED: os_out = omed;
      default:          os_out = omax;                          // code 3 acts as max
    endcase
  end

  // a fatal error raised at this edge also blanks the energy taken at it
  wire        fatal_new = overflow | l2_bad | l1_bad | add_bad;

  // control registers; errors set sticky bits, set beats a same-cycle clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff    <= `CTRL_RST;
      stat_ff    <= '0;
      pu_lim_ff  <= '0;
      spu_lim_ff <= '0;
      e_thr_ff   <= '0;
      e_shf_ff   <= '0;
      t_thr_ff   <= '0;
      a_thr_ff   <= '0;
      e_cof_ff   <= '0;
      t_cof_ff   <= '0;
      prdata_ff  <= '0;
    end else begin
      if (setup) begin
        prdata_ff <= rd_word;
      end
      if (wr) begin
        if (a == `A_CTRL) ctrl_ff <= pwdata[16:0];
        if (a == `A_PILE) {spu_lim_ff, pu_lim_ff} <= pwdata[15:0];
        if (a == `A_ETHR) e_thr_ff <= pwdata[20:0];
        if (a == `A_ESHF) e_shf_ff <= pwdata[4:0];
        if (a == `A_TTHR) t_thr_ff <= pwdata;
        if (in_athr) a_thr_ff[a[4:2]] <= pwdata[19:0];
        if (in_ecof) e_cof_ff[a[4:2]] <= mk1(pwdata[6:0]);
        if (in_tcof) t_cof_ff[a[4:2]] <= mk1(pwdata[6:0]);
      end
      stat_ff <= (stat_ff & ~((wr && a == `A_STAT) ? pwdata[4:0] : 5'h00))
                 | {overflow, l2_bad, l1_bad, add_bad, ecc_fix};
    end
  end

  // memories carry no reset; software loads l2c_mem before use, ring and buffers fill from the datapath
  always_ff @(posedge clk) begin
    ring[wptr_ff] <= enc;
    rd_ff         <= ring[rd_addr];
    byp_ff        <= enc;
    if (wr && in_l2c) begin
      l2c_mem[l2_idx] <= mk2(pwdata[9:0]);
    end
    for (int i = 0; i < N_DRB; i++) begin
      if (alloc && ff[2:0] == 3'(i)) begin
        drb_mem[i][0] <= dword;
      end else if (busy_ff[i] && cnt_ff[i] != `FRAME_LEN) begin
        drb_mem[i][cnt_ff[i][3:0]] <= dword;
      end
    end
  end

  // buffer fill counters; each open buffer runs its own frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_ff <= '0;
      wptr_ff <= '0;
      for (int i = 0; i < N_DRB; i++) begin
        cnt_ff[i] <= '0;
      end
    end else begin
      wptr_ff <= wptr_ff + 8'h01;
      for (int i = 0; i < N_DRB; i++) begin
        if (alloc && ff[2:0] == 3'(i)) begin
          busy_ff[i] <= 1'b1;
          cnt_ff[i]  <= 5'h01;
        end else if (busy_ff[i] && cnt_ff[i] != `FRAME_LEN) begin
          cnt_ff[i] <= cnt_ff[i] + 5'h01;
        end else if (wr_free && pwdata[i]) begin
          busy_ff[i] <= 1'b0;
        end
      end
    end
  end

  // trigger path registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sum_ff    <= '0;
      x_ff      <= '0;
      e_ff      <= '0;
      e1_ff     <= '0;
      t_ff      <= '0;
      t1_ff     <= '0;
      t2_ff     <= '0;
      bcf_ff    <= 1'b0;
      pu_ff     <= 1'b0;
      spu_ff    <= 1'b0;
      gap_ff    <= `GAP_SAT;
      energy_ff <= '0;
    end else begin
      sum_ff <= sum;
      x_ff   <= {x_ff[4:0], sum_ff};
      e_ff   <= e_fir;
      e1_ff  <= e_ff;
      t_ff   <= t_fir;
      t1_ff  <= t_ff;
      t2_ff  <= t1_ff;
      bcf_ff <= bcf_nxt;
      // fatal and non-crossing clocks both send zero energy
      energy_ff <= (bcf_nxt && !fatal_any && !fatal_new) ? e_win : 11'h000;
      if (bcf_ff) begin
        pu_ff  <= gap_ff < pu_lim_ff;
        spu_ff <= gap_ff < spu_lim_ff;
        gap_ff <= 8'h01;
      end else if (gap_ff != `GAP_SAT) begin
        gap_ff <= gap_ff + 8'h01;
      end
    end
  end

  // second-level pipeline
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      y_ff  <= '0;
      l2_ff <= '0;
      for (int f = 0; f < 3; f++) begin
        r_ff[f] <= '0;
      end
    end else begin
      y_ff <= {y_ff[14:0], pipe_dout.sample};
      for (int f = 0; f < 3; f++) begin
        r_ff[f] <= l2_acc[f];
      end
      l2_ff <= os_out;
    end
  end

  // outputs
  assign energy_out   = energy_ff;
  assign bcf_out      = bcf_ff;
  assign pileup_out   = pu_ff;
  assign severe_out   = spu_ff;
  assign l2_result    = l2_ff;
  assign fatal_out    = fatal_any;
  assign nonfatal_out = stat_ff[0];
  always_comb begin
    for (int i = 0; i < N_DRB; i++) begin
      drb_ready[i] = busy_ff[i] && cnt_ff[i] == `FRAME_LEN;
    end
  end

endmodule
